// ---- core/sodd_consts.vh ----
// Constants for the first/second source operand word decoder.
// Assumes inclusion by bare name from the core design files only.
//
// Contract
// - Bit 25 of the first-source word selects flag bank; bits 31:26 stay zero.
// - Bits 24:21 of the first-source word give its vertical stride.
// - Four-element mode: bits 19:16 are swizzle select [7:4]; bit 20 stays zero.
// - Bit 15 of the first-source word selects direct or indirect addressing.
// - Bits 14:13 of the first-source word give its value modifier.
// - Direct addressing: bits 12:5 give the register number.
// - Direct four-element: bit 4 alone gives a 16-byte aligned sub-register.
// - Four-element mode, any addressing: bits 3:0 give the lane enable mask.
// - One-element mode, any addressing: bits 20:18 give the region width.
// - One-element mode, any addressing: bits 17:16 give the horizontal stride.
// - Direct one-element: bits 4:0 give the byte-level sub-register number.
// - Indirect addressing: bits 12:10 select the base address sub-register.
// - Indirect four-element: bits 9:4 are offset upper bits, low four zero.
// - Indirect one-element: bits 9:0 give a byte-aligned address offset.
// - Immediate first source: all its region, address and register fields ignored.
// - Either source immediate: the whole fourth word is the 32-bit immediate.
// - Send instruction: bit 31 of the fourth word ends the thread.
// - Send with immediate second source: low 31 bits are the message descriptor.
// - Direct four-element second source: 31:25, 20 zero; 24:21 stride; 19:16 swizzle.
// - Indirect second-source layouts apply only where that support is enabled.
// - First source is immediate when second-word bits 6:5 hold 11.
// - Flag register holds two 16-bit banks; selected one is predicate source.
`ifndef SODD_CONSTS_VH
`define SODD_CONSTS_VH

// Avalon word indices (byte offset is four times the index)
`define SODD_REG_CTRL    3'h0
`define SODD_REG_WORD1   3'h1
`define SODD_REG_WORD2   3'h2
`define SODD_REG_WORD3   3'h3
`define SODD_REG_STATUS  3'h4
`define SODD_REG_IMM     3'h5
`define SODD_REG_FLAGS   3'h6
`define SODD_REG_FIELDS  3'h7

// Control register bits
`define SODD_CTRL_FOUR   0
`define SODD_CTRL_SEND   1
`define SODD_CTRL_IND1   2
`define SODD_CTRL_RST    32'h0000_0000

// Second instruction word register-file fields
`define SODD_RF0_HI      6
`define SODD_RF0_LO      5
`define SODD_RF1_HI      11
`define SODD_RF1_LO      10
`define SODD_RF_IMM      2'h3

// Source word fields
`define SODD_MBZ0_HI     31
`define SODD_MBZ0_LO     26
`define SODD_MBZ1_LO     25
`define SODD_FLAG_BIT    25
`define SODD_VS_HI       24
`define SODD_VS_LO       21
`define SODD_BIT20       20
`define SODD_CS_HI       19
`define SODD_CS_LO       16
`define SODD_W_HI        20
`define SODD_W_LO        18
`define SODD_HS_HI       17
`define SODD_HS_LO       16
`define SODD_AM_BIT      15
`define SODD_MOD_HI      14
`define SODD_MOD_LO      13
`define SODD_RN_HI       12
`define SODD_RN_LO       5
`define SODD_SR4_BIT     4
`define SODD_SR_HI       4
`define SODD_SR_LO       0
`define SODD_CE_HI       3
`define SODD_CE_LO       0
`define SODD_AS_HI       12
`define SODD_AS_LO       10
`define SODD_AI_HI       9
`define SODD_AI16_LO     4
`define SODD_AI_LO       0
`define SODD_EOT_BIT     31
`define SODD_DESC_HI     30

// Layout codes: {address mode, one-element}
`define SODD_LAY_D4      2'h0
`define SODD_LAY_D1      2'h1
`define SODD_LAY_I4      2'h2
`define SODD_LAY_I1      2'h3

`define SODD_FLAG_BANK_W 16
`define SODD_WORD_ZERO   32'h0000_0000

`endif

// ---- core/sodd_field_extract.v ----
// Combinational field extraction for the first and second source words.
// Assumes stable words from registers on the same clock; no storage here.
`timescale 1ns/100ps
`include "sodd_consts.vh"

module sodd_field_extract (
  input  wire [31:0] word1,
  input  wire [31:0] word2,
  input  wire [31:0] word3,
  input  wire        fourElem,
  input  wire        isSend,
  input  wire        src1IndSupport,
  output reg  [1:0]  layout0,
  output reg         src0Imm,
  output reg         src1Imm,
  output reg         predicateBankSelect,
  output reg  [3:0]  firstSrcRowStep,
  output reg  [3:0]  firstSrcSwizzleSelect,
  output reg         firstSrcAddressingStyle,
  output reg  [1:0]  firstSrcValueModifier,
  output reg  [7:0]  firstSrcRegisterIndex,
  output reg  [4:0]  firstSrcBytePosition,
  output reg  [3:0]  firstSrcLaneMask,
  output reg  [2:0]  firstSrcRowLength,
  output reg  [1:0]  firstSrcElementStep,
  output reg  [2:0]  firstSrcBasePointerSelect,
  output reg  [9:0]  firstSrcOffsetConstant,
  output reg         firstSrcMbzError,
  output reg  [3:0]  secondSrcRowStep,
  output reg  [3:0]  secondSrcSwizzleSelect,
  output reg         secondSrcIndirect,
  output reg         secondSrcMbzError,
  output reg  [31:0] immediateWord,
  output reg         threadFinishBit,
  output reg  [30:0] messageDescriptorField
);

  // Shared by both operands so their layouts can never disagree in encoding
  function [1:0] layoutOf;
    input four;
    input addrMode;
    begin
      layoutOf = {addrMode, ~four};
    end
  endfunction

  reg [1:0] layout1;

  always @* begin
    src0Imm = (word1[`SODD_RF0_HI:`SODD_RF0_LO] == `SODD_RF_IMM);
    src1Imm = (word1[`SODD_RF1_HI:`SODD_RF1_LO] == `SODD_RF_IMM);
    layout0 = layoutOf(fourElem, word2[`SODD_AM_BIT]);
    predicateBankSelect = word2[`SODD_FLAG_BIT];
    firstSrcRowStep = 4'h0;
    firstSrcSwizzleSelect = 4'h0;
    firstSrcAddressingStyle = 1'b0;
    firstSrcValueModifier = 2'h0;
    firstSrcRegisterIndex = 8'h00;
    firstSrcBytePosition = 5'h00;
    firstSrcLaneMask = 4'h0;
    firstSrcRowLength = 3'h0;
    firstSrcElementStep = 2'h0;
    firstSrcBasePointerSelect = 3'h0;
    firstSrcOffsetConstant = 10'h000;
    firstSrcMbzError = 1'b0;
    // Immediate first source leaves every field except the bank select at zero
    if (!src0Imm) begin
      firstSrcRowStep = word2[`SODD_VS_HI:`SODD_VS_LO];
      firstSrcAddressingStyle = word2[`SODD_AM_BIT];
      firstSrcValueModifier = word2[`SODD_MOD_HI:`SODD_MOD_LO];
      firstSrcMbzError = (|word2[`SODD_MBZ0_HI:`SODD_MBZ0_LO]) | (fourElem & word2[`SODD_BIT20]);
      case (layout0)
        `SODD_LAY_D4: begin
          firstSrcRegisterIndex = word2[`SODD_RN_HI:`SODD_RN_LO];
          firstSrcBytePosition = {word2[`SODD_SR4_BIT], 4'h0};
          firstSrcLaneMask = word2[`SODD_CE_HI:`SODD_CE_LO];
          firstSrcSwizzleSelect = word2[`SODD_CS_HI:`SODD_CS_LO];
        end
        `SODD_LAY_D1: begin
          firstSrcRegisterIndex = word2[`SODD_RN_HI:`SODD_RN_LO];
          firstSrcBytePosition = word2[`SODD_SR_HI:`SODD_SR_LO];
          firstSrcRowLength = word2[`SODD_W_HI:`SODD_W_LO];
          firstSrcElementStep = word2[`SODD_HS_HI:`SODD_HS_LO];
        end
        `SODD_LAY_I4: begin
          firstSrcBasePointerSelect = word2[`SODD_AS_HI:`SODD_AS_LO];
          firstSrcOffsetConstant = {word2[`SODD_AI_HI:`SODD_AI16_LO], 4'h0};
          firstSrcLaneMask = word2[`SODD_CE_HI:`SODD_CE_LO];
          firstSrcSwizzleSelect = word2[`SODD_CS_HI:`SODD_CS_LO];
        end
        default: begin
          firstSrcBasePointerSelect = word2[`SODD_AS_HI:`SODD_AS_LO];
          firstSrcOffsetConstant = word2[`SODD_AI_HI:`SODD_AI_LO];
          firstSrcRowLength = word2[`SODD_W_HI:`SODD_W_LO];
          firstSrcElementStep = word2[`SODD_HS_HI:`SODD_HS_LO];
        end
      endcase
    end

    // Second source: indirect layouts only when the option is enabled
    secondSrcIndirect = src1IndSupport & word3[`SODD_AM_BIT] & ~src1Imm & ~src0Imm;
    layout1 = layoutOf(fourElem, secondSrcIndirect);
    secondSrcRowStep = 4'h0;
    secondSrcSwizzleSelect = 4'h0;
    secondSrcMbzError = 1'b0;
    immediateWord = `SODD_WORD_ZERO;
    if (src0Imm | src1Imm) begin
      immediateWord = word3;
    end else begin
      secondSrcRowStep = word3[`SODD_VS_HI:`SODD_VS_LO];
      secondSrcMbzError = |word3[`SODD_MBZ0_HI:`SODD_MBZ1_LO];
      if (layout1 == `SODD_LAY_D4) begin
        secondSrcSwizzleSelect = word3[`SODD_CS_HI:`SODD_CS_LO];
        secondSrcMbzError = (|word3[`SODD_MBZ0_HI:`SODD_MBZ1_LO]) | word3[`SODD_BIT20] | word3[`SODD_AM_BIT];
      end else if (layout1 == `SODD_LAY_I4) begin
        secondSrcSwizzleSelect = word3[`SODD_CS_HI:`SODD_CS_LO];
        secondSrcMbzError = (|word3[`SODD_MBZ0_HI:`SODD_MBZ1_LO]) | word3[`SODD_BIT20];
      end else if (layout1 == `SODD_LAY_D1) begin
        secondSrcMbzError = (|word3[`SODD_MBZ0_HI:`SODD_MBZ1_LO]) | word3[`SODD_AM_BIT];
      end
    end
    // Register second source of a send is trusted to be the address register element
    threadFinishBit = isSend & word3[`SODD_EOT_BIT];
    messageDescriptorField = (isSend & src1Imm) ? word3[`SODD_DESC_HI:0] : 31'h0000_0000;
  end

endmodule // sodd_field_extract

// ---- core/sodd_decoder.v ----
// Top of the source operand word decoder with an Avalon-MM register slave.
// Assumes a synchronous Avalon master on mclk holding requests until waitrequest low.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`include "sodd_consts.vh"

module sodd_decoder (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire [2:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWritedata,
  input  wire [3:0]  avsByteenable,
  output reg  [31:0] avsReaddata,
  output reg         avsWaitrequest,
  output reg         predicateBankSelect,
  output reg  [15:0] predicateFlags,
  output reg         firstSrcIsImm,
  output reg         secondSrcIsImm,
  output reg  [3:0]  firstSrcRowStep,
  output reg  [3:0]  firstSrcSwizzleSelect,
  output reg         firstSrcAddressingStyle,
  output reg  [1:0]  firstSrcValueModifier,
  output reg  [7:0]  firstSrcRegisterIndex,
  output reg  [4:0]  firstSrcBytePosition,
  output reg  [3:0]  firstSrcLaneMask,
  output reg  [2:0]  firstSrcRowLength,
  output reg  [1:0]  firstSrcElementStep,
  output reg  [2:0]  firstSrcBasePointerSelect,
  output reg  [9:0]  firstSrcOffsetConstant,
  output reg         firstSrcMbzError,
  output reg  [3:0]  secondSrcRowStep,
  output reg  [3:0]  secondSrcSwizzleSelect,
  output reg         secondSrcIndirect,
  output reg         secondSrcMbzError,
  output reg  [31:0] immediateWord,
  output reg         threadFinishBit,
  output reg  [30:0] messageDescriptorField
);

  reg  [31:0] ctrl_q;
  reg  [31:0] word1_q;
  reg  [31:0] word2_q;
  reg  [31:0] word3_q;
  reg  [31:0] flags_q;
  reg  [31:0] rdata_d;
  wire [1:0]  layout0;
  wire        src0Imm;
  wire        src1Imm;
  wire        bankSel;
  wire [3:0]  rowStep0;
  wire [3:0]  swz0;
  wire        style0;
  wire [1:0]  mod0;
  wire [7:0]  regIdx0;
  wire [4:0]  bytePos0;
  wire [3:0]  lane0;
  wire [2:0]  rowLen0;
  wire [1:0]  elemStep0;
  wire [2:0]  basePtr0;
  wire [9:0]  offset0;
  wire        mbz0;
  wire [3:0]  rowStep1;
  wire [3:0]  swz1;
  wire        ind1;
  wire        mbz1;
  wire [31:0] immWord;
  wire        finish;
  wire [30:0] descriptor;
  wire        busReq;
  wire        busWr;

  // One wait state: the request is answered on the edge after it is seen
  assign busReq = (avsRead | avsWrite) & avsWaitrequest;
  assign busWr  = avsWrite & ~avsWaitrequest;

  // Byte-lane merge used by every writable register
  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  be;
    integer i;
    begin
      mergeBytes = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  sodd_field_extract u_extract (
    .word1                     (word1_q),
    .word2                     (word2_q),
    .word3                     (word3_q),
    .fourElem                  (ctrl_q[`SODD_CTRL_FOUR]),
    .isSend                    (ctrl_q[`SODD_CTRL_SEND]),
    .src1IndSupport            (ctrl_q[`SODD_CTRL_IND1]),
    .layout0                   (layout0),
    .src0Imm                   (src0Imm),
    .src1Imm                   (src1Imm),
    .predicateBankSelect       (bankSel),
    .firstSrcRowStep           (rowStep0),
    .firstSrcSwizzleSelect     (swz0),
    .firstSrcAddressingStyle   (style0),
    .firstSrcValueModifier     (mod0),
    .firstSrcRegisterIndex     (regIdx0),
    .firstSrcBytePosition      (bytePos0),
    .firstSrcLaneMask          (lane0),
    .firstSrcRowLength         (rowLen0),
    .firstSrcElementStep       (elemStep0),
    .firstSrcBasePointerSelect (basePtr0),
    .firstSrcOffsetConstant    (offset0),
    .firstSrcMbzError          (mbz0),
    .secondSrcRowStep          (rowStep1),
    .secondSrcSwizzleSelect    (swz1),
    .secondSrcIndirect         (ind1),
    .secondSrcMbzError         (mbz1),
    .immediateWord             (immWord),
    .threadFinishBit           (finish),
    .messageDescriptorField    (descriptor)
  );

  // Read mux; unmapped indices do not exist with a 3-bit address
  always @* begin
    rdata_d = `SODD_WORD_ZERO;
    case (avsAddress)
      `SODD_REG_CTRL: begin
        rdata_d = ctrl_q;
      end
      `SODD_REG_WORD1: begin
        rdata_d = word1_q;
      end
      `SODD_REG_WORD2: begin
        rdata_d = word2_q;
      end
      `SODD_REG_WORD3: begin
        rdata_d = word3_q;
      end
      `SODD_REG_STATUS: begin
        rdata_d = {24'h00_0000, layout0, mbz1, mbz0, finish, bankSel, src1Imm, src0Imm};
      end
      `SODD_REG_IMM: begin
        rdata_d = immWord;
      end
      `SODD_REG_FLAGS: begin
        rdata_d = flags_q;
      end
      `SODD_REG_FIELDS: begin
        rdata_d = {4'h0, rowStep0, swz0, style0, mod0, regIdx0, bytePos0, 4'h0};
      end
      default: begin
        rdata_d = `SODD_WORD_ZERO;
      end
    endcase
  end

  // Bus slave and software-visible registers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= `SODD_WORD_ZERO;
      ctrl_q         <= `SODD_CTRL_RST;
      word1_q        <= `SODD_WORD_ZERO;
      word2_q        <= `SODD_WORD_ZERO;
      word3_q        <= `SODD_WORD_ZERO;
      flags_q        <= `SODD_WORD_ZERO;
    end else begin
      avsWaitrequest <= ~busReq;
      if (busReq && avsRead) begin
        avsReaddata <= rdata_d;
      end
      if (busWr) begin
        case (avsAddress)
          `SODD_REG_CTRL: begin
            ctrl_q <= mergeBytes(ctrl_q, avsWritedata, avsByteenable) & 32'h0000_0007;
          end
          `SODD_REG_WORD1: begin
            word1_q <= mergeBytes(word1_q, avsWritedata, avsByteenable);
          end
          `SODD_REG_WORD2: begin
            word2_q <= mergeBytes(word2_q, avsWritedata, avsByteenable);
          end
          `SODD_REG_WORD3: begin
            word3_q <= mergeBytes(word3_q, avsWritedata, avsByteenable);
          end
          `SODD_REG_FLAGS: begin
            flags_q <= mergeBytes(flags_q, avsWritedata, avsByteenable);
          end
          default: begin
            flags_q <= flags_q;
          end
        endcase
      end
    end
  end

  // Decoded outputs registered so every output leaves a flip-flop
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      predicateBankSelect       <= 1'b0;
      predicateFlags            <= 16'h0000;
      firstSrcIsImm             <= 1'b0;
      secondSrcIsImm            <= 1'b0;
      firstSrcRowStep           <= 4'h0;
      firstSrcSwizzleSelect     <= 4'h0;
      firstSrcAddressingStyle   <= 1'b0;
      firstSrcValueModifier     <= 2'h0;
      firstSrcRegisterIndex     <= 8'h00;
      firstSrcBytePosition      <= 5'h00;
      firstSrcLaneMask          <= 4'h0;
      firstSrcRowLength         <= 3'h0;
      firstSrcElementStep       <= 2'h0;
      firstSrcBasePointerSelect <= 3'h0;
      firstSrcOffsetConstant    <= 10'h000;
      firstSrcMbzError          <= 1'b0;
      secondSrcRowStep          <= 4'h0;
      secondSrcSwizzleSelect    <= 4'h0;
      secondSrcIndirect         <= 1'b0;
      secondSrcMbzError         <= 1'b0;
      immediateWord             <= `SODD_WORD_ZERO;
      threadFinishBit           <= 1'b0;
      messageDescriptorField    <= 31'h0000_0000;
    end else begin
      predicateBankSelect       <= bankSel;
      // Selected bank feeds predication; flags change only through bus writes
      predicateFlags            <= bankSel ? flags_q[2*`SODD_FLAG_BANK_W-1:`SODD_FLAG_BANK_W]
                                           : flags_q[`SODD_FLAG_BANK_W-1:0];
      firstSrcIsImm             <= src0Imm;
      secondSrcIsImm            <= src1Imm;
      firstSrcRowStep           <= rowStep0;
      firstSrcSwizzleSelect     <= swz0;
      firstSrcAddressingStyle   <= style0;
      firstSrcValueModifier     <= mod0;
      firstSrcRegisterIndex     <= regIdx0;
      firstSrcBytePosition      <= bytePos0;
      firstSrcLaneMask          <= lane0;
      firstSrcRowLength         <= rowLen0;
      firstSrcElementStep       <= elemStep0;
      firstSrcBasePointerSelect <= basePtr0;
      firstSrcOffsetConstant    <= offset0;
      firstSrcMbzError          <= mbz0;
      secondSrcRowStep          <= rowStep1;
      secondSrcSwizzleSelect    <= swz1;
      secondSrcIndirect         <= ind1;
      secondSrcMbzError         <= mbz1;
      immediateWord             <= immWord;
      threadFinishBit           <= finish;
      messageDescriptorField    <= descriptor;
    end
  end

endmodule // sodd_decoder

// ---- tb/sodd_decoder_checker.sv ----
// Checker for the decoder top ports: bus handshake and decode timing.
// Assumes one mclk domain, rst_b async low, decode valid two edges after a write.
`timescale 1ns/100ps
module sodd_decoder_checker (
  input wire        mclk,
  input wire        rst_b,
  input wire [2:0]  avsAddress,
  input wire        avsRead,
  input wire        avsWrite,
  input wire [31:0] avsWritedata,
  input wire [3:0]  avsByteenable,
  input wire        avsWaitrequest,
  input wire        predicateBankSelect,
  input wire        firstSrcIsImm,
  input wire        secondSrcIsImm,
  input wire [3:0]  firstSrcRowStep,
  input wire        firstSrcAddressingStyle,
  input wire [1:0]  firstSrcValueModifier,
  input wire [7:0]  firstSrcRegisterIndex,
  input wire [3:0]  firstSrcLaneMask,
  input wire [9:0]  firstSrcOffsetConstant,
  input wire        firstSrcMbzError,
  input wire [31:0] immediateWord
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Full-word writes only, so the write data is the expected word
  wire wrDone    = avsWrite && !avsWaitrequest && (avsByteenable == 4'hf);
  wire w1        = wrDone && (avsAddress == 3'h1);
  wire w2        = wrDone && (avsAddress == 3'h2);
  wire w3        = wrDone && (avsAddress == 3'h3);
  wire immCode   = (avsWritedata[6:5] == 2'h3);
  wire eitherImm = firstSrcIsImm || secondSrcIsImm;
  AST_WAIT: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("no answer after one wait state");
  AST_ONE_LOW: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low too long");
  AST_BANK: assert property (w2 |-> ##2 (predicateBankSelect == $past(avsWritedata[25], 2)))
    else $error("bank select wrong");
  AST_ROW_STEP: assert property (w2 |-> ##2 (firstSrcIsImm || firstSrcRowStep == $past(avsWritedata[24:21], 2)))
    else $error("row step wrong");
  AST_STYLE: assert property (w2 |-> ##2 (firstSrcIsImm || firstSrcAddressingStyle == $past(avsWritedata[15], 2)))
    else $error("addressing style wrong");
  AST_MODIFIER: assert property (w2 |-> ##2 (firstSrcIsImm || firstSrcValueModifier == $past(avsWritedata[14:13], 2)))
    else $error("modifier wrong");
  AST_ZERO_BITS: assert property (w2 && (|avsWritedata[31:26]) |-> ##2 (firstSrcIsImm || firstSrcMbzError))
    else $error("nonzero upper bits not flagged");
  AST_IMM_SEL: assert property (w1 |-> ##2 (firstSrcIsImm == $past(immCode, 2)))
    else $error("first source immediate flag wrong");
  AST_IMM_FIELDS: assert property (firstSrcIsImm |-> (firstSrcRegisterIndex == 8'h00 && firstSrcLaneMask == 4'h0 &&
    firstSrcOffsetConstant == 10'h000 && !firstSrcAddressingStyle))
    else $error("immediate fields not zero");
  AST_IMM_WORD: assert property (w3 |-> ##2 (immediateWord == (eitherImm ? $past(avsWritedata, 2) : 32'h0000_0000)))
    else $error("immediate word wrong");
  COV_IMM: cover property (w1 ##2 firstSrcIsImm);
  COV_ZERO_BITS: cover property (w2 ##2 firstSrcMbzError);
  COV_WORD3: cover property (w3 ##2 (immediateWord != 32'h0000_0000));
endmodule // sodd_decoder_checker

bind sodd_decoder sodd_decoder_checker sodd_decoder_checker_inst (.mclk, .rst_b, .avsAddress, .avsRead, .avsWrite,
  .avsWritedata, .avsByteenable, .avsWaitrequest, .predicateBankSelect, .firstSrcIsImm, .secondSrcIsImm,
  .firstSrcRowStep, .firstSrcAddressingStyle, .firstSrcValueModifier, .firstSrcRegisterIndex, .firstSrcLaneMask,
  .firstSrcOffsetConstant, .firstSrcMbzError, .immediateWord);

// ---- tb/sodd_avalon_master.sv ----
// Avalon-MM master model standing in for the instruction loader.
// Assumes a slave on mclk that answers by dropping waitrequest.
`timescale 1ns/100ps
module sodd_avalon_master (
  input  wire         mclk,
  input  wire         avsWaitrequest,
  input  wire  [31:0] avsReaddata,
  output logic [2:0]  avsAddress = 3'h0,
  output logic        avsRead = 1'b0,
  output logic        avsWrite = 1'b0,
  output logic [31:0] avsWritedata = 32'h0000_0000,
  output logic [3:0]  avsByteenable = 4'h0
);
  // Idle lines flip so the slave cannot lean on stale values
  task automatic release_bus();
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    avsAddress <= ~avsAddress;
    avsWritedata <= ~avsWritedata;
    avsByteenable <= ~avsByteenable;
  endtask
  task automatic bus_write(input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    avsAddress <= a;
    avsWritedata <= d;
    avsByteenable <= be;
    avsWrite <= 1'b1;
    do @(posedge mclk); while (avsWaitrequest !== 1'b0);
    release_bus();
  endtask
  task automatic bus_read(input logic [2:0] a, output logic [31:0] d);
    @(posedge mclk);
    avsAddress <= a;
    avsByteenable <= 4'hf;
    avsRead <= 1'b1;
    do @(posedge mclk); while (avsWaitrequest !== 1'b0);
    d = avsReaddata;
    release_bus();
  endtask
endmodule // sodd_avalon_master

// ---- tb/sodd_decoder_tb.sv ----
// Self-checking bench for the source operand word decoder.
// Assumes the master model drives the register bus; one 10 MHz clock.
`timescale 1ns/100ps
module sodd_decoder_tb;
  logic        mclk;
  logic        rst_b = 1'b0;
  logic [2:0]  avsAddress, firstSrcRowLength, firstSrcBasePointerSelect;
  logic        avsRead, avsWrite, avsWaitrequest, predicateBankSelect, firstSrcIsImm, secondSrcIsImm;
  logic        firstSrcAddressingStyle, firstSrcMbzError, secondSrcIndirect, secondSrcMbzError, threadFinishBit;
  logic [31:0] avsWritedata, avsReaddata, immediateWord, r;
  logic [3:0]  avsByteenable, firstSrcRowStep, firstSrcSwizzleSelect, firstSrcLaneMask, secondSrcRowStep;
  logic [3:0]  secondSrcSwizzleSelect;
  logic [1:0]  firstSrcValueModifier, firstSrcElementStep;
  logic [7:0]  firstSrcRegisterIndex;
  logic [4:0]  firstSrcBytePosition;
  logic [9:0]  firstSrcOffsetConstant;
  logic [15:0] predicateFlags;
  logic [30:0] messageDescriptorField;
  int          miscompares = 0;
  int          compares = 0;
  wire  [47:0] f0 = {predicateBankSelect, firstSrcRowStep, firstSrcSwizzleSelect, firstSrcAddressingStyle,
    firstSrcValueModifier, firstSrcRegisterIndex, firstSrcBytePosition, firstSrcLaneMask, firstSrcRowLength,
    firstSrcElementStep, firstSrcBasePointerSelect, firstSrcOffsetConstant, firstSrcMbzError};
  wire  [9:0]  f1 = {secondSrcRowStep, secondSrcSwizzleSelect, secondSrcIndirect, secondSrcMbzError};

  sodd_decoder sodd_decoder_inst (.*);
  sodd_avalon_master sodd_avalon_master_inst (.*);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    sodd_avalon_master_inst.bus_write(a, d, 4'hf);
  endtask
  task automatic rd(input logic [2:0] a);
    sodd_avalon_master_inst.bus_read(a, r);
  endtask
  // Decode lands one edge after the register write, so two edges settle it
  task automatic load(input logic [31:0] c, w1, w2, w3);
    wr(3'h0, c);
    wr(3'h1, w1);
    wr(3'h2, w2);
    wr(3'h3, w3);
    repeat (2) @(posedge mclk);
  endtask

  task automatic scn_reset();
    rst_b <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("waitrequest", 1, avsWaitrequest);
    chk("fields", 0, f0);
    rst_b <= 1'b1;
    rd(3'h0);
    chk("ctrl", 0, r);
  endtask
  task automatic scn_direct_four();
    load(32'h0000_0001, 32'h0000_0000, 32'h0345_5879, 32'h0000_0000);
    chk("d4 fields", {1'b1, 4'ha, 4'h5, 1'b0, 2'h2, 8'hc3, 5'h10, 4'h9, 3'h0, 2'h0, 3'h0, 10'h000, 1'b0}, f0);
    rd(3'h4);
    chk("d4 status", 32'h0000_0004, r);
    rd(3'h7);
    chk("d4 field reg", 32'h0a55_8700, r);
  endtask
  task automatic scn_direct_one();
    load(32'h0000_0000, 32'h0000_0000, 32'h0076_2fdb, 32'h0000_0000);
    chk("d1 fields", {1'b0, 4'h3, 4'h0, 1'b0, 2'h1, 8'h7e, 5'h1b, 4'h0, 3'h5, 2'h2, 3'h0, 10'h000, 1'b0}, f0);
    rd(3'h4);
    chk("d1 status", 32'h0000_0040, r);
  endtask
  task automatic scn_indirect_four();
    load(32'h0000_0001, 32'h0000_0000, 32'h062c_fad3, 32'h0000_0000);
    chk("i4 fields", {1'b1, 4'h1, 4'hc, 1'b1, 2'h3, 8'h00, 5'h00, 4'h3, 3'h0, 2'h0, 3'h6, 10'h2d0, 1'b1}, f0);
    rd(3'h4);
    chk("i4 status", 32'h0000_0094, r);
  endtask
  task automatic scn_indirect_one();
    load(32'h0000_0000, 32'h0000_0000, 32'h0049_87a5, 32'h0000_0000);
    chk("i1 fields", {1'b0, 4'h2, 4'h0, 1'b1, 2'h0, 8'h00, 5'h00, 4'h0, 3'h2, 2'h1, 3'h1, 10'h3a5, 1'b0}, f0);
    rd(3'h4);
    chk("i1 status", 32'h0000_00c0, r);
  endtask
  task automatic scn_first_imm();
    load(32'h0000_0001, 32'h0000_0060, 32'h0345_5879, 32'h1234_5678);
    chk("imm fields", 48'h8000_0000_0000, f0);
    chk("imm flag", 1, firstSrcIsImm);
    chk("imm word", 32'h1234_5678, immediateWord);
    chk("src1 fields", 0, f1);
    wr(3'h5, 32'hffff_ffff);
    rd(3'h5);
    chk("imm reg", 32'h1234_5678, r);
  endtask
  task automatic scn_send_imm();
    load(32'h0000_0002, 32'h0000_0c00, 32'h0000_0000, 32'h8abc_def1);
    chk("finish", 1, threadFinishBit);
    chk("descriptor", 31'h0abc_def1, messageDescriptorField);
    chk("imm word", 32'h8abc_def1, immediateWord);
    chk("src1 imm", 1, secondSrcIsImm);
    wr(3'h0, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk("no send finish", 0, threadFinishBit);
    chk("no send descriptor", 0, messageDescriptorField);
  endtask
  task automatic scn_send_reg();
    load(32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h8000_0000);
    chk("finish", 1, threadFinishBit);
    chk("descriptor", 0, messageDescriptorField);
    chk("imm word", 0, immediateWord);
  endtask
  task automatic scn_second_src();
    load(32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h00fb_8000);
    chk("src1 fields", {4'h7, 4'hb, 1'b0, 1'b1}, f1);
    wr(3'h0, 32'h0000_0005);
    repeat (2) @(posedge mclk);
    chk("src1 indirect", 1, secondSrcIndirect);
  endtask
  task automatic scn_flags();
    wr(3'h0, 32'hffff_ffff);
    rd(3'h0);
    chk("ctrl spare bits", 32'h0000_0007, r);
    wr(3'h6, 32'hbeef_1234);
    sodd_avalon_master_inst.bus_write(3'h6, 32'hffff_5a5a, 4'h3);
    rd(3'h6);
    chk("flags", 32'hbeef_5a5a, r);
    load(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    chk("bank0", 16'h5a5a, predicateFlags);
    wr(3'h2, 32'h0200_0000);
    repeat (2) @(posedge mclk);
    chk("bank1", 16'hbeef, predicateFlags);
  endtask

  initial begin
    scn_reset();
    scn_direct_four();
    scn_direct_one();
    scn_indirect_four();
    scn_indirect_one();
    scn_first_imm();
    scn_send_imm();
    scn_send_reg();
    scn_second_src();
    scn_flags();
    scn_reset();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    complete_run();
  end
endmodule // sodd_decoder_tb
